// ===== include/isc_map.vh
// register offsets, field positions and codes of the interrupt service block
// assumes a 32-bit wishbone slave, one aligned word per register
`ifndef ISC_MAP_VH
`define ISC_MAP_VH
// ==========================================
// geometry
`define ISC_NSRC 22
`define ISC_ADR_W 8
// ==========================================
// register byte addresses
`define ISC_A_CTRL0 8'h00
`define ISC_A_MASK_LOW 8'h60
`define ISC_A_MASK_HIGH 8'h64
`define ISC_A_INSVC 8'h68
`define ISC_A_NEST 8'h6C
`define ISC_A_WDMODE 8'h70
`define ISC_A_STATUS 8'h74
// ==========================================
// per-source control register fields
`define ISC_F_PRIO_LO 0
`define ISC_F_PRIO_HI 1
`define ISC_F_CSE 4
`define ISC_F_MACRO 5
`define ISC_F_MASK 6
`define ISC_F_REQ 7
`define ISC_PRIO_RST 2'h3
// sources without macro service (receive-error sources 14 and 18)
`define ISC_NO_MACRO 22'h044000
// ==========================================
// other fields and reset values
`define ISC_F_IRQ_EN 0
`define ISC_F_NEST3 0
`define ISC_F_WD_FIRST 0
`define ISC_F_INSVC_NMI 4
`define ISC_F_INSVC_WDT 5
`define ISC_STATUS_RST 1'h0
`define ISC_NEST_RST 1'h0
`define ISC_WDMODE_RST 1'h0
// ==========================================
// service modes and acknowledge identifiers
`define ISC_MODE_VEC 2'h0
`define ISC_MODE_BANK 2'h1
`define ISC_MODE_MACRO 2'h2
`define ISC_ID_NMI_PIN 6'h20
`define ISC_ID_NMI_WDT 6'h21
`define ISC_ID_OPERR 6'h22
`define ISC_ID_TRAP_VEC 6'h23
`define ISC_ID_TRAP_BANK 6'h24
`endif

// ===== rtl/isc_core.v
// interrupt acknowledge and service-mode selection with wishbone registers
// assumes i_clk at 200 MHz, cpu sequencer answers acks and return pulses
// Notes on behaviour
// - both trap instructions acked with global enable clear; plain vectored, other bank-switched.
// - illegal operand on standby, watchdog mode or relocate raises operand-error request.
// - operand-error requests ignore global enable and priority levels.
// - non-maskable request comes from pin or watchdog overflow.
// - non-maskable acked unless same or higher non-maskable service is running.
// - non-maskable outranks every class and ignores programmable levels.
// - a maskable source is blocked while its mask flag is set.
// - global enable in status word gates all maskable acks except macro service.
// - equal-level simultaneous maskable requests follow fixed source index order.
// - four programmable levels with nesting control.
// - macro-service requests ignore levels and global enable.
// - per-source vectored, bank-switch or macro service; some sources lack macro.
// - vectored ack asks core to stack pc and status word then vector.
// - macro ack holds the cpu during a hardware transfer, nothing saved.
// - bank-switch ack selects bank, saves pc and status there, vectors from bank.
// - each source owns a control register: request, mask, mode, bank enable, level.
// - grouped mask registers mirror per-source masks, word or byte access.
// - in-service record holds levels currently being serviced.
// - nesting control lets level-3 requests nest among themselves.
// - watchdog mode register picks which non-maskable source ranks higher.
// - level zero is the highest maskable priority.
// - reset sets all priority bits to one.
`timescale 1ns/10ps
`include "isc_map.vh"

module isc_core (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [21:0] i_src_event,
  input wire i_nmi_pin,
  input wire i_wdt_ovf,
  input wire i_trap_vec,
  input wire i_trap_bank,
  input wire i_bad_standby_op,
  input wire i_bad_wdmode_op,
  input wire i_bad_reloc_op,
  input wire i_cpu_ready,
  input wire i_svc_return,
  input wire i_macro_done,
  output reg o_ack,
  output reg [5:0] o_ack_id,
  output reg [1:0] o_ack_mode,
  output reg o_save_to_stack,
  output reg o_save_to_bank,
  output reg o_cpu_hold
);

  // ==========================================
  // reset release
  reg rst_s1;
  reg rst_s2;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  // ==========================================
  // bus slave: ack one cycle after request, write lands on the ack edge
  wire wb_req = i_wb_cyc & i_wb_stb;
  wire wb_wr = wb_req & i_wb_we & o_wb_ack;
  wire [5:0] wb_idx = i_wb_adr[7:2];
  wire ctrl_hit = (wb_idx < 6'h16);
  wire wr_b0 = wb_wr & i_wb_sel[0];
  wire wr_b1 = wb_wr & i_wb_sel[1];

  // ==========================================
  // per-source control registers
  reg [1:0] prio [0:21];
  reg [21:0] mask;
  reg [21:0] cse;
  reg [21:0] macro;
  reg [21:0] req;
  reg [21:0] clr_by_ack;
  reg [3:0] insvc;
  reg nmi_pin_svc;
  reg nmi_wdt_svc;
  reg global_irq_enable;
  reg nest3;
  reg wd_first;
  localparam [21:0] NO_MACRO = `ISC_NO_MACRO;

  genvar g;
  generate
    for (g = 0; g < 22; g = g + 1) begin : g_src
      wire ctrl_wr = wr_b0 & ctrl_hit & (wb_idx == g);
      wire mk_wr = (g < 16) ?
        (wb_wr & (i_wb_adr == `ISC_A_MASK_LOW) & i_wb_sel[g/8]) :
        (wr_b0 & (i_wb_adr == `ISC_A_MASK_HIGH));
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          prio[g] <= `ISC_PRIO_RST;
          mask[g] <= 1'b1;
          cse[g] <= 1'b0;
          macro[g] <= 1'b0;
          req[g] <= 1'b0;
        end else begin
          if (ctrl_wr) begin
            prio[g] <= i_wb_dat[`ISC_F_PRIO_HI:`ISC_F_PRIO_LO];
            cse[g] <= i_wb_dat[`ISC_F_CSE];
            macro[g] <= i_wb_dat[`ISC_F_MACRO] & ~NO_MACRO[g];
            mask[g] <= i_wb_dat[`ISC_F_MASK];
          end else if (mk_wr) begin
            // the high group starts again at bit 0 for source 16
            mask[g] <= i_wb_dat[g % 16];
          end
          // event wins over both software clear and acknowledge clear
          if (i_src_event[g])
            req[g] <= 1'b1;
          else if (ctrl_wr)
            req[g] <= i_wb_dat[`ISC_F_REQ];
          else if (clr_by_ack[g])
            req[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================
  // misc control registers
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nest3 <= `ISC_NEST_RST;
      wd_first <= `ISC_WDMODE_RST;
    end else begin
      if (wr_b0 & (i_wb_adr == `ISC_A_NEST))
        nest3 <= i_wb_dat[`ISC_F_NEST3];
      if (wr_b0 & (i_wb_adr == `ISC_A_WDMODE))
        wd_first <= i_wb_dat[`ISC_F_WD_FIRST];
    end
  end

  // ==========================================
  // pending non-maskable, operand-error and trap requests
  reg nmi_pin_pend;
  reg nmi_wdt_pend;
  reg operr_pend;
  reg trapv_pend;
  reg trapb_pend;
  reg take_pin;
  reg take_wdt;
  reg take_oe;
  reg take_tv;
  reg take_tb;
  wire any_bad = i_bad_standby_op | i_bad_wdmode_op | i_bad_reloc_op;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pin_pend <= 1'b0;
      nmi_wdt_pend <= 1'b0;
      operr_pend <= 1'b0;
      trapv_pend <= 1'b0;
      trapb_pend <= 1'b0;
    end else begin
      nmi_pin_pend <= i_nmi_pin | (nmi_pin_pend & ~take_pin);
      nmi_wdt_pend <= i_wdt_ovf | (nmi_wdt_pend & ~take_wdt);
      operr_pend <= any_bad | (operr_pend & ~take_oe);
      trapv_pend <= i_trap_vec | (trapv_pend & ~take_tv);
      trapb_pend <= i_trap_bank | (trapb_pend & ~take_tb);
    end
  end

  // ==========================================
  // arbitration
  reg pin_ok;
  reg wdt_ok;
  reg [21:0] elig_m;
  reg [21:0] elig_mac;
  reg sel_m;
  reg [4:0] sel_m_idx;
  reg sel_mac;
  reg [4:0] sel_mac_idx;
  reg go;
  reg [5:0] next_id;
  reg [1:0] next_mode;
  reg lvl_ok;
  reg [3:0] le_mask;
  integer i;
  integer l;

  always @* begin
    // a pin request is shut out by its own routine, or the wdt one if it ranks higher
    pin_ok = nmi_pin_pend & ~nmi_pin_svc & ~(nmi_wdt_svc & wd_first);
    wdt_ok = nmi_wdt_pend & ~nmi_wdt_svc & ~(nmi_pin_svc & ~wd_first);
    elig_m = 22'h000000;
    elig_mac = 22'h000000;
    le_mask = 4'h0;
    lvl_ok = 1'b0;
    for (i = 0; i < 22; i = i + 1) begin
      case (prio[i])
        2'h0: le_mask = 4'h1;
        2'h1: le_mask = 4'h3;
        2'h2: le_mask = 4'h7;
        default: le_mask = 4'hF;
      endcase
      // level 0 is highest; equal or higher level in service blocks nesting
      lvl_ok = ((insvc & le_mask) == 4'h0) |
        ((prio[i] == 2'h3) & nest3 & (insvc[2:0] == 3'h0));
      elig_m[i] = req[i] & ~mask[i] & ~macro[i] & global_irq_enable & lvl_ok &
        ~nmi_pin_svc & ~nmi_wdt_svc;
      elig_mac[i] = req[i] & ~mask[i] & macro[i];
    end
    sel_m = 1'b0;
    sel_m_idx = 5'h00;
    sel_mac = 1'b0;
    sel_mac_idx = 5'h00;
    // scan downward so the last hit is the best level, then the lowest index
    for (l = 3; l >= 0; l = l - 1) begin
      for (i = 21; i >= 0; i = i - 1) begin
        if (elig_m[i] & (prio[i] == l[1:0])) begin
          sel_m = 1'b1;
          sel_m_idx = i[4:0];
        end
      end
    end
    for (i = 21; i >= 0; i = i - 1) begin
      if (elig_mac[i]) begin
        sel_mac = 1'b1;
        sel_mac_idx = i[4:0];
      end
    end
    take_pin = 1'b0;
    take_wdt = 1'b0;
    take_oe = 1'b0;
    take_tv = 1'b0;
    take_tb = 1'b0;
    clr_by_ack = 22'h000000;
    next_id = 6'h00;
    next_mode = `ISC_MODE_VEC;
    go = i_cpu_ready & ~o_cpu_hold & ~o_ack;
    if (go) begin
      // fixed class order: non-maskable, operand error, traps, macro, maskable
      if ((pin_ok & ~(wdt_ok & wd_first)) | (pin_ok & ~wdt_ok)) begin
        take_pin = 1'b1;
        next_id = `ISC_ID_NMI_PIN;
      end else if (wdt_ok) begin
        take_wdt = 1'b1;
        next_id = `ISC_ID_NMI_WDT;
      end else if (operr_pend) begin
        take_oe = 1'b1;
        next_id = `ISC_ID_OPERR;
      end else if (trapv_pend) begin
        take_tv = 1'b1;
        next_id = `ISC_ID_TRAP_VEC;
      end else if (trapb_pend) begin
        take_tb = 1'b1;
        next_id = `ISC_ID_TRAP_BANK;
        next_mode = `ISC_MODE_BANK;
      end else if (sel_mac) begin
        clr_by_ack[sel_mac_idx] = 1'b1;
        next_id = {1'b0, sel_mac_idx};
        next_mode = `ISC_MODE_MACRO;
      end else if (sel_m) begin
        clr_by_ack[sel_m_idx] = 1'b1;
        next_id = {1'b0, sel_m_idx};
        next_mode = cse[sel_m_idx] ? `ISC_MODE_BANK : `ISC_MODE_VEC;
      end else begin
        go = 1'b0;
      end
    end
  end

  // ==========================================
  // acknowledge outputs and service state
  wire macro_ack = go & (next_mode == `ISC_MODE_MACRO);
  wire mask_ack = go & sel_m & (next_id[5] == 1'b0) & ~macro_ack;
  wire [1:0] ack_lvl = prio[sel_m_idx];
  reg [3:0] ret_clr;

  always @* begin
    ret_clr = 4'h0;
    if (insvc[0])
      ret_clr = 4'h1;
    else if (insvc[1])
      ret_clr = 4'h2;
    else if (insvc[2])
      ret_clr = 4'h4;
    else if (insvc[3])
      ret_clr = 4'h8;
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ack <= 1'b0;
      o_ack_id <= 6'h00;
      o_ack_mode <= `ISC_MODE_VEC;
      o_save_to_stack <= 1'b0;
      o_save_to_bank <= 1'b0;
      o_cpu_hold <= 1'b0;
      insvc <= 4'h0;
      nmi_pin_svc <= 1'b0;
      nmi_wdt_svc <= 1'b0;
      global_irq_enable <= `ISC_STATUS_RST;
    end else begin
      o_ack <= go;
      if (go) begin
        o_ack_id <= next_id;
        o_ack_mode <= next_mode;
      end
      o_save_to_stack <= go & (next_mode == `ISC_MODE_VEC);
      o_save_to_bank <= go & (next_mode == `ISC_MODE_BANK);
      // macro transfer: cpu frozen, no context saved
      if (macro_ack)
        o_cpu_hold <= 1'b1;
      else if (i_macro_done)
        o_cpu_hold <= 1'b0;
      // return retires a non-maskable routine before any level (the lower-ranked one if both run), else the highest-ranked level
      if (take_pin)
        nmi_pin_svc <= 1'b1;
      else if (i_svc_return & nmi_pin_svc & (wd_first | ~nmi_wdt_svc))
        nmi_pin_svc <= 1'b0;
      if (take_wdt)
        nmi_wdt_svc <= 1'b1;
      else if (i_svc_return & nmi_wdt_svc & (~wd_first | ~nmi_pin_svc))
        nmi_wdt_svc <= 1'b0;
      // a return in the ack cycle retires the old routine and records the new one
      if (mask_ack & i_svc_return)
        insvc <= (insvc & ~ret_clr) | (4'h1 << ack_lvl);
      else if (mask_ack)
        insvc <= insvc | (4'h1 << ack_lvl);
      else if (i_svc_return & ~nmi_pin_svc & ~nmi_wdt_svc)
        insvc <= insvc & ~ret_clr;
      // ack of a cpu-serviced request disables further vectored and bank-switched maskable acks
      if (go & ~macro_ack)
        global_irq_enable <= 1'b0;
      else if (wr_b0 & (i_wb_adr == `ISC_A_STATUS))
        global_irq_enable <= i_wb_dat[`ISC_F_IRQ_EN];
    end
  end

  // ==========================================
  // bus read path
  reg [31:0] rd;
  always @* begin
    rd = 32'h00000000;
    if (ctrl_hit) begin
      rd[`ISC_F_PRIO_HI:`ISC_F_PRIO_LO] = prio[wb_idx[4:0]];
      rd[`ISC_F_CSE] = cse[wb_idx[4:0]];
      rd[`ISC_F_MACRO] = macro[wb_idx[4:0]];
      rd[`ISC_F_MASK] = mask[wb_idx[4:0]];
      rd[`ISC_F_REQ] = req[wb_idx[4:0]];
    end else begin
      case (i_wb_adr)
        `ISC_A_MASK_LOW: rd[15:0] = mask[15:0];
        `ISC_A_MASK_HIGH: rd[5:0] = mask[21:16];
        `ISC_A_INSVC: begin
          rd[3:0] = insvc;
          rd[`ISC_F_INSVC_NMI] = nmi_pin_svc;
          rd[`ISC_F_INSVC_WDT] = nmi_wdt_svc;
        end
        `ISC_A_NEST: rd[`ISC_F_NEST3] = nest3;
        `ISC_A_WDMODE: rd[`ISC_F_WD_FIRST] = wd_first;
        `ISC_A_STATUS: rd[`ISC_F_IRQ_EN] = global_irq_enable;
        default: rd = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      o_wb_dat <= rd;
    end
  end

endmodule // isc_core

// ===== tb/isc_checker.sv
// port-level assertions for the interrupt service block
// assumes a single clock domain and the map header on the include path
`timescale 1ns/10ps
`include "isc_map.vh"
module isc_checker (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire i_macro_done,
  input wire o_ack,
  input wire [5:0] o_ack_id,
  input wire [1:0] o_ack_mode,
  input wire o_save_to_stack,
  input wire o_save_to_bank,
  input wire o_cpu_hold
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // properties
  property p_wb_answer; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  property p_wb_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  property p_vec_save; o_ack && o_ack_mode == `ISC_MODE_VEC |-> o_save_to_stack && !o_save_to_bank; endproperty
  property p_bank_save; o_ack && o_ack_mode == `ISC_MODE_BANK |-> o_save_to_bank && !o_save_to_stack; endproperty
  property p_macro_nosave; o_ack && o_ack_mode == `ISC_MODE_MACRO |-> o_cpu_hold && !o_save_to_stack && !o_save_to_bank; endproperty
  property p_save_only_ack; o_save_to_stack || o_save_to_bank |-> o_ack; endproperty
  property p_hold_keep; o_cpu_hold && !i_macro_done |=> o_cpu_hold; endproperty
  property p_hold_end; o_cpu_hold && i_macro_done |-> ##[1:2] !o_cpu_hold; endproperty
  property p_no_ack_hold; $past(o_cpu_hold) |-> !o_ack; endproperty
  property p_macro_src; o_ack && o_ack_mode == `ISC_MODE_MACRO |-> o_ack_id < 6'h16 && o_ack_id != 6'h0E && o_ack_id != 6'h12; endproperty
  property p_trap_vec; o_ack && o_ack_id == `ISC_ID_TRAP_VEC |-> o_ack_mode == `ISC_MODE_VEC; endproperty
  property p_trap_bank; o_ack && o_ack_id == `ISC_ID_TRAP_BANK |-> o_ack_mode == `ISC_MODE_BANK; endproperty
  // ==========================================
  // assertions
  a_wb_answer: assert property (p_wb_answer) else $error("bus request not answered");
  a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack longer than one cycle");
  a_vec_save: assert property (p_vec_save) else $error("vectored ack without stack save");
  a_bank_save: assert property (p_bank_save) else $error("bank ack without bank save");
  a_macro_nosave: assert property (p_macro_nosave) else $error("macro ack saved state");
  a_save_only_ack: assert property (p_save_only_ack) else $error("save pulse without ack");
  a_hold_keep: assert property (p_hold_keep) else $error("cpu hold dropped early");
  a_hold_end: assert property (p_hold_end) else $error("cpu hold stuck after transfer");
  a_no_ack_hold: assert property (p_no_ack_hold) else $error("ack during cpu hold");
  a_macro_src: assert property (p_macro_src) else $error("macro ack from bad source");
  a_trap_vec: assert property (p_trap_vec) else $error("plain trap not vectored");
  a_trap_bank: assert property (p_trap_bank) else $error("bank trap not bank switched");
  c_macro: cover property (o_ack && o_ack_mode == `ISC_MODE_MACRO);
  c_bank: cover property (o_ack && o_ack_mode == `ISC_MODE_BANK);
  c_hold_end: cover property ($fell(o_cpu_hold));
endmodule // isc_checker

// ===== tb/isc_cpu_model.sv
// cpu sequencer stand-in: ready handshake and macro transfer completion
// assumes the block clock; slow mode stalls ready and stretches transfers
`timescale 1ns/10ps
module isc_cpu_model (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_slow,
  input wire i_cpu_hold,
  output reg o_cpu_ready,
  output reg o_macro_done
);
  reg [2:0] cnt;
  // ==========================================
  // handshake
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 3'h0;
      o_cpu_ready <= 1'b0;
      o_macro_done <= 1'b0;
    end else begin
      o_cpu_ready <= !i_slow || !o_cpu_ready;
      // count only while held so the done pulse fires once per transfer
      if (!i_cpu_hold)
        cnt <= 3'h0;
      else if (cnt != 3'h7)
        cnt <= cnt + 3'h1;
      o_macro_done <= i_cpu_hold && (cnt == (i_slow ? 3'h6 : 3'h1));
    end
  end
endmodule // isc_cpu_model

// ===== tb/isc_core_tb_top.sv
// self-checking bench for the interrupt service block
// assumes the design, the cpu model and the checker are compiled first
`timescale 1ns/10ps
`include "isc_map.vh"
module isc_core_tb_top;
  logic i_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_cpu_ready, i_macro_done;
  logic o_ack, o_save_to_stack, o_save_to_bank, o_cpu_hold, slow;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic [29:0] ev;
  logic [5:0] o_ack_id;
  logic [1:0] o_ack_mode;
  int fails, compares;
  localparam logic [29:0] PIN = 30'h0400000, WDT = 30'h0800000, RET = 30'h20000000;
  isc_core dut (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_src_event(ev[21:0]), .i_nmi_pin(ev[22]),
    .i_wdt_ovf(ev[23]), .i_trap_vec(ev[24]), .i_trap_bank(ev[25]), .i_bad_standby_op(ev[26]),
    .i_bad_wdmode_op(ev[27]), .i_bad_reloc_op(ev[28]), .i_cpu_ready, .i_svc_return(ev[29]),
    .i_macro_done, .o_ack, .o_ack_id, .o_ack_mode, .o_save_to_stack, .o_save_to_bank,
    .o_cpu_hold);
  isc_cpu_model cpu (.i_clk, .i_rst_n, .i_slow(slow), .i_cpu_hold(o_cpu_hold),
    .o_cpu_ready(i_cpu_ready), .o_macro_done(i_macro_done));
  // ==========================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    check(nm, rd, exp);
  endtask
  task automatic go(input logic [29:0] v);
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= 30'h0;
  endtask
  task automatic irq(input logic [5:0] id, input logic [1:0] md);
    int n;
    n = 0;
    while (o_ack !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    check("ack", {31'h0, o_ack}, 32'h1);
    check("ack_id", {26'h0, o_ack_id}, {26'h0, id});
    check("ack_mode", {30'h0, o_ack_mode}, {30'h0, md});
    check("save_stack", {31'h0, o_save_to_stack}, {31'h0, md == `ISC_MODE_VEC});
    check("save_bank", {31'h0, o_save_to_bank}, {31'h0, md == `ISC_MODE_BANK});
  endtask
  task automatic quiet(input int k);
    int n;
    n = 0;
    repeat (k) begin
      @(negedge i_clk);
      if (o_ack !== 1'b0) n++;
    end
    check("no_ack", n, 32'h0);
  endtask
  task automatic test_done;
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, sequence
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #(5 * 20000);
    fails++;
    test_done();
  end
  initial begin
    {i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, slow} = 5'h0;
    {i_wb_adr, i_wb_sel, i_wb_dat, ev} = '0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rc("ctrl0", 8'h00, 32'h43);
    rc("mask_lo", `ISC_A_MASK_LOW, 32'hFFFF);
    rc("mask_hi", `ISC_A_MASK_HIGH, 32'h3F);
    rc("unmapped", 8'hFC, 32'h0);
    wb(1'b1, `ISC_A_MASK_LOW, 32'hF7, 4'h1);
    rc("ctrl3", 8'h0C, 32'h03);
    w(8'h00, 32'h00);
    rc("mask_lo", `ISC_A_MASK_LOW, 32'hFFF6);
    // lane 1 alone must leave the low byte untouched
    wb(1'b1, `ISC_A_MASK_LOW, 32'h7F00, 4'h2);
    rc("mask_lo", `ISC_A_MASK_LOW, 32'h7FF6);
    w(`ISC_A_MASK_HIGH, 32'h15);
    rc("mask_hi", `ISC_A_MASK_HIGH, 32'h15);
    rc("ctrl16", 8'h40, 32'h43);
    rc("ctrl17", 8'h44, 32'h03);
    go(30'h28);
    quiet(8);
    rc("ctrl3", 8'h0C, 32'h83);
    w(`ISC_A_STATUS, 32'h1);
    irq(6'h03, `ISC_MODE_VEC);
    rc("insvc", `ISC_A_INSVC, 32'h08);
    rc("ctrl3", 8'h0C, 32'h03);
    go(RET);
    w(`ISC_A_STATUS, 32'h1);
    quiet(8);
    wb(1'b1, `ISC_A_MASK_LOW, 32'hD6, 4'h1);
    irq(6'h05, `ISC_MODE_VEC);
    go(RET);
    // level 0 source beside two level 3 sources
    w(8'h04, 32'h03);
    go(30'h0B);
    w(`ISC_A_STATUS, 32'h1);
    irq(6'h00, `ISC_MODE_VEC);
    w(`ISC_A_STATUS, 32'h1);
    quiet(8);
    go(RET);
    irq(6'h01, `ISC_MODE_VEC);
    w(`ISC_A_STATUS, 32'h1);
    quiet(8);
    w(`ISC_A_NEST, 32'h1);
    irq(6'h03, `ISC_MODE_VEC);
    go(RET);
    w(`ISC_A_NEST, 32'h0);
    slow <= 1'b1;
    go(30'h1000000);
    irq(`ISC_ID_TRAP_VEC, `ISC_MODE_VEC);
    go(30'h2000000);
    irq(`ISC_ID_TRAP_BANK, `ISC_MODE_BANK);
    for (int i = 0; i < 3; i++) begin
      go(30'h4000000 << i);
      irq(`ISC_ID_OPERR, `ISC_MODE_VEC);
    end
    slow <= 1'b0;
    go(PIN);
    irq(`ISC_ID_NMI_PIN, `ISC_MODE_VEC);
    rc("insvc", `ISC_A_INSVC, 32'h10);
    go(PIN);
    quiet(8);
    go(RET);
    irq(`ISC_ID_NMI_PIN, `ISC_MODE_VEC);
    go(RET);
    w(`ISC_A_WDMODE, 32'h1);
    w(`ISC_A_STATUS, 32'h1);
    go(PIN | WDT | 30'h8);
    irq(`ISC_ID_NMI_WDT, `ISC_MODE_VEC);
    quiet(8);
    go(RET);
    irq(`ISC_ID_NMI_PIN, `ISC_MODE_VEC);
    go(RET);
    w(`ISC_A_STATUS, 32'h1);
    irq(6'h03, `ISC_MODE_VEC);
    go(RET);
    w(`ISC_A_WDMODE, 32'h0);
    w(8'h0C, 32'h13);
    go(30'h8);
    w(`ISC_A_STATUS, 32'h1);
    irq(6'h03, `ISC_MODE_BANK);
    go(RET);
    w(8'h0C, 32'h23);
    slow <= 1'b1;
    go(30'h8);
    irq(6'h03, `ISC_MODE_MACRO);
    check("hold_on", {31'h0, o_cpu_hold}, 32'h1);
    quiet(12);
    check("hold", {31'h0, o_cpu_hold}, 32'h0);
    w(8'h38, 32'h23);
    rc("ctrl14", 8'h38, 32'h03);
    test_done();
  end
endmodule // isc_core_tb_top
bind isc_core isc_checker u_chk (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
  .i_macro_done, .o_ack, .o_ack_id, .o_ack_mode, .o_save_to_stack, .o_save_to_bank,
  .o_cpu_hold);
